// file: verilog/evt_gate.sv
// Purpose: per-channel event qualification with enable masks and wishbone registers
// Assumes: single 40 MHz clock, event inputs already synchronous to it
// Notes: one channel is handed to the queue per accepted grant
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "evt_gate_regs.svh"
module evt_gate
  import evt_gate_pkg::*;
#(
  parameter int CHANNELS = 64
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire evt_gate_pkg::word_t i_wb_dat,
  output evt_gate_pkg::word_t o_wb_dat,
  output logic o_wb_ack,
  // event sources
  input wire evt_gate_pkg::chan_vec_t i_ext_event,
  input wire logic i_chain_valid,
  input wire logic [5:0] i_chain_code,
  // submission toward the queues
  output logic o_submit_valid,
  output logic [5:0] o_submit_chan,
  output evt_gate_pkg::pick_src_e o_submit_src,
  input wire logic i_submit_ready,
  output logic o_irq
);
  import evt_gate_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  chan_vec_t event_flags_ff;
  chan_vec_t chained_flags_ff;
  chan_vec_t manual_flags_ff;
  chan_vec_t enable_mask_ff;
  chan_vec_t missed_ff;
  logic [`IRQ_BITS-1:0] irq_status_ff;
  logic [`IRQ_BITS-1:0] irq_mask_ff;
  logic ack_ff;
  word_t rdata_ff;
  logic sub_valid_ff;
  logic [5:0] sub_chan_ff;
  pick_src_e sub_src_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic bus_req;
  logic wr_en;
  word_t wmask;
  word_t wdat;
  assign bus_req = i_wb_cyc && i_wb_stb && !ack_ff;
  // writes land on the edge where the master samples ack, never on the taking edge
  assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign wdat = i_wb_dat & wmask;

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_en && (i_wb_adr == ofs);
  endfunction

  chan_vec_t set_wr;
  chan_vec_t clr_wr;
  chan_vec_t man_wr;
  chan_vec_t miss_clr;
  logic [`IRQ_BITS-1:0] irq_w1c;
  // decoded in a process: hit reads bus signals that an assign would not react to
  always_comb begin
    set_wr = {hit(`OFS_ENABLE_SET_PORT_HIGH) ? wdat : 32'h0000_0000,
              hit(`OFS_ENABLE_SET_PORT_LOW) ? wdat : 32'h0000_0000};
    clr_wr = {hit(`OFS_ENABLE_CLEAR_PORT_HIGH) ? wdat : 32'h0000_0000,
              hit(`OFS_ENABLE_CLEAR_PORT_LOW) ? wdat : 32'h0000_0000};
    man_wr = {hit(`OFS_MANUAL_TRIGGER_HIGH) ? wdat : 32'h0000_0000,
              hit(`OFS_MANUAL_TRIGGER_LOW) ? wdat : 32'h0000_0000};
    miss_clr = {hit(`OFS_MISSED_RECORD_HIGH) ? wdat : 32'h0000_0000,
                hit(`OFS_MISSED_RECORD_LOW) ? wdat : 32'h0000_0000};
    irq_w1c = hit(`OFS_IRQ_STATUS) ? wdat[`IRQ_BITS-1:0] : '0;
  end

  // ----------------------------------------------------------------
  // grant and clear-on-service
  // ----------------------------------------------------------------
  chan_vec_t chain_set;
  chan_vec_t ext_ready;
  chan_vec_t grant_vec;
  logic grant_any;
  logic [5:0] grant_idx;
  logic take;
  pick_src_e grant_src;

  assign chain_set = i_chain_valid ? (64'h1 << i_chain_code) : 64'h0;
  assign ext_ready = event_flags_ff & enable_mask_ff;

  evt_pick #(
    .CHANNELS(CHANNELS)
  ) u_pick (
    .i_req(ext_ready | chained_flags_ff | manual_flags_ff),
    .o_any(grant_any),
    .o_idx(grant_idx)
  );

  // a grant is only taken when the output slot is free or draining
  assign take = grant_any && (!sub_valid_ff || i_submit_ready);
  assign grant_vec = take ? (64'h1 << grant_idx) : 64'h0;

  always_comb begin
    if (manual_flags_ff[grant_idx]) begin
      grant_src = SRC_MANUAL;
    end else if (chained_flags_ff[grant_idx]) begin
      grant_src = SRC_CHAINED;
    end else if (ext_ready[grant_idx]) begin
      grant_src = SRC_EXTERNAL;
    end else begin
      grant_src = SRC_NONE;
    end
  end

  // service consumes one source per grant, the highest one picked
  chan_vec_t srv_man;
  chan_vec_t srv_chn;
  chan_vec_t srv_ext;
  assign srv_man = (grant_src == SRC_MANUAL) ? grant_vec : 64'h0;
  assign srv_chn = (grant_src == SRC_CHAINED) ? grant_vec : 64'h0;
  assign srv_ext = (grant_src == SRC_EXTERNAL) ? grant_vec : 64'h0;

  // ----------------------------------------------------------------
  // per-channel flags
  // ----------------------------------------------------------------
  chan_vec_t nxt_missed;
  chan_vec_t nxt_enable;
  chan_vec_t nxt_event;
  chan_vec_t nxt_chained;
  chan_vec_t nxt_manual;
  logic missed_pulse;
  logic disabled_pulse;

  for (genvar g = 0; g < 64; g++) begin : g_chan
    assign nxt_missed[g] = (i_ext_event[g] && event_flags_ff[g])
                        || (chain_set[g] && chained_flags_ff[g])
                        || (man_wr[g] && manual_flags_ff[g])
                        || (missed_ff[g] && !miss_clr[g]);
    assign nxt_enable[g] = clr_wr[g] ? 1'b0 : (set_wr[g] ? 1'b1 : enable_mask_ff[g]);
    assign nxt_chained[g] = chain_set[g] || (chained_flags_ff[g] && !srv_chn[g]);
    assign nxt_event[g] = i_ext_event[g] || (event_flags_ff[g] && !srv_ext[g]);
    assign nxt_manual[g] = man_wr[g] || (manual_flags_ff[g] && !srv_man[g]);
  end

  assign missed_pulse = |(nxt_missed & ~missed_ff);
  assign disabled_pulse = |(i_ext_event & ~enable_mask_ff);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      event_flags_ff <= 64'h0;
      manual_flags_ff <= 64'h0;
      missed_ff <= 64'h0;
    end else begin
      event_flags_ff <= nxt_event;
      manual_flags_ff <= nxt_manual;
      missed_ff <= nxt_missed;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      chained_flags_ff <= 64'h0;
    end else begin
      chained_flags_ff <= nxt_chained;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      enable_mask_ff <= 64'h0;
    end else begin
      enable_mask_ff <= nxt_enable;
    end
  end

  // ----------------------------------------------------------------
  // submission output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sub_valid_ff <= 1'b0;
      sub_chan_ff <= 6'h00;
      sub_src_ff <= SRC_NONE;
    end else if (take) begin
      sub_valid_ff <= 1'b1;
      sub_chan_ff <= grant_idx;
      sub_src_ff <= grant_src;
    end else if (i_submit_ready) begin
      sub_valid_ff <= 1'b0;
    end
  end

  assign o_submit_valid = sub_valid_ff;
  assign o_submit_chan = sub_chan_ff;
  assign o_submit_src = sub_src_ff;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [`IRQ_BITS-1:0] irq_set;
  assign irq_set[`IRQ_BIT_MISSED] = missed_pulse;
  assign irq_set[`IRQ_BIT_DISABLED_EVENT] = disabled_pulse;

  // a new event in the clearing cycle keeps its bit
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= irq_set | (irq_status_ff & ~irq_w1c);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      irq_mask_ff <= '0;
    end else if (hit(`OFS_IRQ_MASK)) begin
      irq_mask_ff <= wdat[`IRQ_BITS-1:0];
    end
  end

  assign o_irq = |(irq_status_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  word_t rd_mux;
  always_comb begin
    case (i_wb_adr)
      `OFS_EVENT_FLAGS_LOW: rd_mux = event_flags_ff[31:0];
      `OFS_EVENT_FLAGS_HIGH: rd_mux = event_flags_ff[63:32];
      `OFS_CHAINED_FLAGS_LOW: rd_mux = chained_flags_ff[31:0];
      `OFS_CHAINED_FLAGS_HIGH: rd_mux = chained_flags_ff[63:32];
      `OFS_EVENT_ENABLE_MASK_LOW: rd_mux = enable_mask_ff[31:0];
      `OFS_EVENT_ENABLE_MASK_HIGH: rd_mux = enable_mask_ff[63:32];
      `OFS_MANUAL_TRIGGER_LOW: rd_mux = manual_flags_ff[31:0];
      `OFS_MANUAL_TRIGGER_HIGH: rd_mux = manual_flags_ff[63:32];
      `OFS_MISSED_RECORD_LOW: rd_mux = missed_ff[31:0];
      `OFS_MISSED_RECORD_HIGH: rd_mux = missed_ff[63:32];
      `OFS_IRQ_STATUS: rd_mux = {30'h0000_0000, irq_status_ff};
      `OFS_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_ff};
      // write-only ports and unmapped words read as zero
      default: rd_mux = `UNMAPPED_READ_VALUE;
    endcase
  end

  // one wait-free answer: ack one cycle after the strobe, dropped next cycle
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
      rdata_ff <= `REG_RESET_VALUE;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !i_wb_we) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdata_ff;
endmodule

// file: verilog/evt_gate_regs.svh
// Purpose: register offsets, field positions and reset values for the event gating block
// Assumes: 32-bit classic Wishbone, byte addresses, one register per aligned word
// Notes: offsets are local to the block
`ifndef EVT_GATE_REGS_SVH
`define EVT_GATE_REGS_SVH

`define OFS_EVENT_FLAGS_LOW        8'h00
`define OFS_EVENT_FLAGS_HIGH       8'h04
`define OFS_CHAINED_FLAGS_LOW      8'h08
`define OFS_CHAINED_FLAGS_HIGH     8'h0C
`define OFS_EVENT_ENABLE_MASK_LOW  8'h10
`define OFS_EVENT_ENABLE_MASK_HIGH 8'h14
`define OFS_ENABLE_CLEAR_PORT_LOW  8'h18
`define OFS_ENABLE_CLEAR_PORT_HIGH 8'h1C
`define OFS_ENABLE_SET_PORT_LOW    8'h20
`define OFS_ENABLE_SET_PORT_HIGH   8'h24
`define OFS_MANUAL_TRIGGER_LOW     8'h28
`define OFS_MANUAL_TRIGGER_HIGH    8'h2C
`define OFS_MISSED_RECORD_LOW      8'h30
`define OFS_MISSED_RECORD_HIGH     8'h34
`define OFS_IRQ_STATUS             8'h38
`define OFS_IRQ_MASK               8'h3C

`define REG_RESET_VALUE            32'h0000_0000
`define UNMAPPED_READ_VALUE        32'h0000_0000

`define IRQ_BIT_MISSED             0
`define IRQ_BIT_DISABLED_EVENT     1
`define IRQ_BITS                   2

`endif

// file: verilog/evt_gate_pkg.sv
// Purpose: shared types for the event gating block
// Assumes: 64 channels split in two 32-bit halves
// Notes: constants live in evt_gate_regs.svh
package evt_gate_pkg;
  typedef logic [31:0] word_t;
  typedef logic [63:0] chan_vec_t;
  typedef logic [7:0] reg_addr_t;
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_EXTERNAL,
    SRC_CHAINED,
    SRC_MANUAL
  } pick_src_e;
endpackage

// file: verilog/evt_pick.sv
// Purpose: fixed-priority pick of the lowest pending channel
// Assumes: one grant per cycle
// Notes: lowest channel number wins
`timescale 1ns/1ps
module evt_pick #(
  parameter int CHANNELS = 64
) (
  input wire logic [CHANNELS-1:0] i_req,
  output logic o_any,
  output logic [$clog2(CHANNELS)-1:0] o_idx
);
  always_comb begin
    o_any = 1'b0;
    o_idx = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_idx = i[$clog2(CHANNELS)-1:0];
      end
    end
  end
endmodule

// file: sim/evt_gate_sva.sv
// Purpose: port-level assertions for evt_gate
// Assumes: one clock, async active-high reset
// Notes: bound below to every evt_gate instance
`timescale 1ns/1ps
`include "evt_gate_regs.svh"
module evt_gate_sva
  import evt_gate_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire evt_gate_pkg::word_t o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_chain_valid,
  input wire logic o_submit_valid,
  input wire logic [5:0] o_submit_chan,
  input wire evt_gate_pkg::pick_src_e o_submit_src,
  input wire logic i_submit_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_read(logic [7:0] a);
    s_take ##0 (!i_wb_we && i_wb_adr == a);
  endsequence
  chk_ack_answer: assert property (s_take |=> o_wb_ack)
    else $error("request not answered next cycle");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (!i_wb_cyc |=> !o_wb_ack)
    else $error("ack without a request");
  chk_clr_lo_wo: assert property (
    s_read(`OFS_ENABLE_CLEAR_PORT_LOW) |=> o_wb_dat == 32'h0) else $error("clear low readable");
  chk_clr_hi_wo: assert property (
    s_read(`OFS_ENABLE_CLEAR_PORT_HIGH) |=> o_wb_dat == 32'h0) else $error("clear high readable");
  chk_set_lo_wo: assert property (
    s_read(`OFS_ENABLE_SET_PORT_LOW) |=> o_wb_dat == 32'h0) else $error("set low readable");
  chk_offer_hold: assert property (
    o_submit_valid && !i_submit_ready |=> o_submit_valid && $stable(o_submit_chan)
      && $stable(o_submit_src)) else $error("offer changed before acceptance");
  chk_chain_offer: assert property (
    i_chain_valid && !o_submit_valid |-> ##[1:3] o_submit_valid)
    else $error("chained code not offered in time");
  chk_offer_src: assert property (
    o_submit_valid |-> o_submit_src != SRC_NONE) else $error("offer without a source");
endmodule

bind evt_gate evt_gate_sva chk (
  .i_clk_sys, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
  .i_chain_valid, .o_submit_valid, .o_submit_chan, .o_submit_src, .i_submit_ready
);

// file: sim/evt_queue_model.sv
// Purpose: queue-side partner taking offers from the gating block
// Assumes: ready follows the stall input at once
// Notes: keeps last accepted channel, source and a running count
`timescale 1ns/1ps
module evt_queue_model
  import evt_gate_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire logic [5:0] i_chan,
  input wire evt_gate_pkg::pick_src_e i_src,
  input wire logic i_stall,
  output logic o_ready,
  output logic [5:0] o_chan,
  output evt_gate_pkg::pick_src_e o_src,
  output logic [7:0] o_count
);
  // a stalled queue refuses at once, as a full one would
  assign o_ready = !i_stall;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_chan <= 6'h00;
      o_src <= SRC_NONE;
      o_count <= 8'h00;
    end else if (i_valid && o_ready) begin
      o_chan <= i_chan;
      o_src <= i_src;
      o_count <= o_count + 8'h01;
    end
  end
endmodule

// file: sim/tb_evt_gate.sv
// Purpose: self-checking bench for evt_gate
// Assumes: one bus access at a time
// Notes: queue model stalls on request
`timescale 1ns/1ps
`include "evt_gate_regs.svh"
module tb_evt_gate;
  import evt_gate_pkg::*;
  logic i_clk_sys, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_chain_valid;
  logic o_submit_valid, i_submit_ready, o_irq, stall;
  logic [7:0] i_wb_adr, q_count, exp_cnt;
  logic [3:0] i_wb_sel;
  logic [5:0] i_chain_code, o_submit_chan, q_chan;
  word_t i_wb_dat, o_wb_dat;
  chan_vec_t i_ext_event;
  pick_src_e o_submit_src, q_src;
  int failures, checked;
  evt_gate uut (.i_clk_sys, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_ext_event, .i_chain_valid, .i_chain_code,
    .o_submit_valid, .o_submit_chan, .o_submit_src, .i_submit_ready, .o_irq);
  evt_queue_model partner (.i_clk_sys, .i_reset, .i_valid(o_submit_valid),
    .i_chan(o_submit_chan), .i_src(o_submit_src), .i_stall(stall), .o_ready(i_submit_ready),
    .o_chan(q_chan), .o_src(q_src), .o_count(q_count));
  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait step: a hang ends the run as a failure
  task automatic tick(inout int n);
    @(posedge i_clk_sys);
    n++;
    if (n > 30) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic w, input reg_addr_t a, input word_t d);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    while (o_wb_ack !== 1'b1) tick(n);
    if (!w) chk(o_wb_dat, d);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic sub(input logic [5:0] c, input pick_src_e s);
    int n;
    n = 0;
    while (q_count !== exp_cnt + 8'h01) tick(n);
    exp_cnt = exp_cnt + 8'h01;
    chk(word_t'(q_chan), word_t'(c));
    chk(word_t'(q_src), word_t'(s));
  endtask
  task automatic pulse(input chan_vec_t e);
    i_ext_event <= e;
    @(posedge i_clk_sys);
    i_ext_event <= 64'h0;
    @(posedge i_clk_sys);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_reset = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 8'h00;
    i_wb_sel = 4'hF;
    i_wb_dat = 32'h0;
    i_ext_event = 64'h0;
    i_chain_valid = 1'b0;
    i_chain_code = 6'h00;
    stall = 1'b0;
    exp_cnt = 8'h00;
    failures = 0;
    checked = 0;
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    xfer(1'b0, `OFS_CHAINED_FLAGS_HIGH, 32'h0);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_LOW, 32'h0);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_HIGH, 32'h0);
    xfer(1'b0, `OFS_ENABLE_CLEAR_PORT_LOW, 32'h0);
    xfer(1'b0, 8'hFC, 32'h0);
    xfer(1'b1, `OFS_EVENT_ENABLE_MASK_LOW, 32'hFFFF_FFFF);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_LOW, 32'h0);
    xfer(1'b1, `OFS_ENABLE_SET_PORT_LOW, 32'h0000_00F0);
    xfer(1'b1, `OFS_ENABLE_CLEAR_PORT_LOW, 32'h0000_0030);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_LOW, 32'h0000_00C0);
    xfer(1'b1, `OFS_ENABLE_SET_PORT_HIGH, 32'h0000_0003);
    xfer(1'b1, `OFS_ENABLE_CLEAR_PORT_HIGH, 32'h0000_0001);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_HIGH, 32'h0000_0002);
    xfer(1'b0, `OFS_ENABLE_CLEAR_PORT_HIGH, 32'h0);
    xfer(1'b0, `OFS_ENABLE_SET_PORT_LOW, 32'h0);
    // one disabled and one enabled channel in the same cycle
    pulse(64'h0000_0000_0000_0048);
    sub(6'h06, SRC_EXTERNAL);
    xfer(1'b0, `OFS_EVENT_FLAGS_LOW, 32'h0000_0008);
    chk(word_t'(q_count), word_t'(exp_cnt));
    pulse(64'h0000_0002_0000_0000);
    sub(6'h21, SRC_EXTERNAL);
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h0000_0002);
    chk(word_t'(o_irq), 32'h0);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h0000_0002);
    chk(word_t'(o_irq), 32'h1);
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h0000_0002);
    chk(word_t'(o_irq), 32'h0);
    xfer(1'b1, `OFS_ENABLE_SET_PORT_LOW, 32'h0000_0008);
    sub(6'h03, SRC_EXTERNAL);
    // chained code on a disabled channel while the queue stalls
    stall <= 1'b1;
    i_chain_valid <= 1'b1;
    i_chain_code <= 6'h28;
    @(posedge i_clk_sys);
    i_chain_valid <= 1'b0;
    xfer(1'b0, `OFS_CHAINED_FLAGS_HIGH, 32'h0000_0100);
    stall <= 1'b0;
    sub(6'h28, SRC_CHAINED);
    xfer(1'b0, `OFS_CHAINED_FLAGS_HIGH, 32'h0);
    xfer(1'b1, `OFS_MANUAL_TRIGGER_LOW, 32'h0000_0010);
    sub(6'h04, SRC_MANUAL);
    xfer(1'b1, `OFS_ENABLE_CLEAR_PORT_LOW, 32'h0000_0008);
    pulse(64'h0000_0000_0000_0008);
    pulse(64'h0000_0000_0000_0008);
    xfer(1'b0, `OFS_MISSED_RECORD_LOW, 32'h0000_0008);
    chk(word_t'(q_count), word_t'(exp_cnt));
    // second chained code lands in the grant cycle: set must win, one code is missed
    i_chain_valid <= 1'b1;
    i_chain_code <= 6'h29;
    repeat (2) @(posedge i_clk_sys);
    i_chain_valid <= 1'b0;
    sub(6'h29, SRC_CHAINED);
    sub(6'h29, SRC_CHAINED);
    xfer(1'b0, `OFS_MISSED_RECORD_HIGH, 32'h0000_0200);
    // reset in mid-run must clear masks and latched flags
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    exp_cnt = 8'h00;
    @(posedge i_clk_sys);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_LOW, 32'h0);
    xfer(1'b0, `OFS_EVENT_ENABLE_MASK_HIGH, 32'h0);
    xfer(1'b0, `OFS_EVENT_FLAGS_LOW, 32'h0);
    xfer(1'b0, `OFS_CHAINED_FLAGS_HIGH, 32'h0);
    complete_run();
  end
endmodule
